// ---- rtl/cpm_pkg.sv ----
// Package with constants and types for the core power-mode P-Channel block
package cpm_pkg;
  localparam int PSTATE_W = 6;
  localparam int PACTIVE_W = 9;
  typedef enum logic [5:0] {
    PS_OFF    = 6'h00,
    PS_EMU    = 6'h01,
    PS_RET    = 6'h05,
    PS_ON     = 6'h08,
    PS_DBGREC = 6'h0a
  } cpm_pstate_t;
  localparam int PA_ON_BIT = 8;
  localparam int PA_RET_BIT = 5;
  localparam int PA_EMU_BIT = 1;
  localparam int PA_OFF_BIT = 0;
  typedef enum logic [1:0] {
    DOM_OFF = 2'b00,
    DOM_RET = 2'b01,
    DOM_ON  = 2'b10
  } cpm_dom_t;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_CLEAN = 2'b01,
    HS_INVAL = 2'b10,
    HS_DONE  = 2'b11
  } cpm_hs_t;
  // Register map
  localparam logic [31:0] REG_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] REG_STAT_ADDR = 32'h0000_0004;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_PWRDN_BIT = 0;
  localparam int TO_W = 3;
  localparam int CTRL_WFI_LSB = 1;
  localparam int CTRL_WFE_LSB = 4;
  localparam int CTRL_EMU_BIT = 7;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_DOM_LSB = 8;
  localparam int STAT_SKIP_BIT = 10;
  localparam int STAT_STALL_BIT = 11;
  localparam int STAT_HS_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RET_TICK_NS = 80;
  localparam int RET_TICK_CYCLES = (RET_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [1:0] INIT_WAIT = 2'h2;
endpackage

// ---- rtl/cpm_ret_timer.sv ----
// Retention entry timeout counter for one wait state
`timescale 1ns/1ps
module cpm_ret_timer
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic idle,
  input wire logic [TO_W-1:0] timeout,
  // Status
  output logic expired
);
  logic [TMR_W-1:0] cnt_ff;
  logic expired_ff;
  logic [TMR_W-1:0] limit;
  logic [TMR_W-1:0] nxt_cnt;
  logic nxt_expired;

  // Zero timeout disables entry from this wait state
  assign limit = TMR_W'(timeout) * TMR_W'(RET_TICK_CYCLES);
  assign nxt_cnt = (!idle || expired_ff) ? '0 : cnt_ff + TMR_W'(1);
  assign nxt_expired = idle && (timeout != '0) &&
                       (expired_ff || (cnt_ff + TMR_W'(1) >= limit));
  assign expired = expired_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      expired_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      expired_ff <= nxt_expired;
    end
  end
endmodule

// ---- rtl/cpm_core_power.sv ----
// Per-core power-mode P-Channel device end with AXI4-Lite control registers
`timescale 1ns/1ps
module cpm_core_power
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // P-Channel
  input wire logic preq,
  input wire logic [PSTATE_W-1:0] pstate,
  output logic paccept,
  output logic pdeny,
  output logic [PACTIVE_W-1:0] pactive,
  // Core activity
  input wire logic wfiState,
  input wire logic wfeState,
  input wire logic snoopReq,
  input wire logic gicReq,
  input wire logic dbgReq,
  // Cache maintenance
  output logic cacheCleanReq,
  input wire logic cacheCleanDone,
  output logic cacheInvReq,
  input wire logic cacheInvDone,
  // Access answers and domain control
  output logic dbgErr,
  output logic dbgGrant,
  output logic funcGrant,
  output logic accessStall,
  output logic funcIsolate,
  output logic [1:0] domState
);
  function automatic logic addrHit(input logic [31:0] a, input logic [31:0] r);
    addrHit = (a[31:2] == r[31:2]);
  endfunction

  // Pin synchronisers
  logic preqS1_ff, preqS2_ff;
  logic [PSTATE_W-1:0] pstS1_ff, pstS2_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      preqS1_ff <= 1'b0;
      preqS2_ff <= 1'b0;
      pstS1_ff <= '0;
      pstS2_ff <= '0;
    end else begin
      preqS1_ff <= preq;
      preqS2_ff <= preqS1_ff;
      pstS1_ff <= pstate;
      pstS2_ff <= pstS1_ff;
    end
  end

  // Registers and state
  logic [7:0] ctrl_ff;
  cpm_pstate_t mode_ff, tgt_ff;
  cpm_hs_t hs_ff;
  logic [1:0] initCnt_ff;
  logic initDone_ff, skipInv_ff, quiet_ff;
  logic paccept_ff, pdeny_ff;
  logic [PACTIVE_W-1:0] pactive_ff;
  logic cleanReq_ff, invReq_ff;
  logic dbgErr_ff, dbgGrant_ff, funcGrant_ff, stall_ff, isolate_ff;
  cpm_dom_t dom_ff;
  logic wfiExp, wfeExp;

  // Decode
  wire cpm_pstate_t reqSt = cpm_pstate_t'(pstS2_ff);
  wire anyReq = snoopReq | gicReq | dbgReq;
  wire modeOn = (mode_ff == PS_ON);
  wire modeRet = (mode_ff == PS_RET);
  wire modeOff = (mode_ff == PS_OFF);
  wire modeEmu = (mode_ff == PS_EMU);
  wire pwrdnBit = ctrl_ff[CTRL_PWRDN_BIT];
  wire emuBit = ctrl_ff[CTRL_EMU_BIT];
  wire waitIdle = (wfiState | wfeState) & ~anyReq;
  wire retWanted = ((wfiState & wfiExp) | (wfeState & wfeExp)) & ~anyReq;
  wire offWanted = pwrdnBit & wfiState & ~anyReq;
  wire emuWanted = offWanted & emuBit;
  wire newReq = initDone_ff & preqS2_ff & (hs_ff == HS_IDLE);
  // Legal transitions; anything else, or a stale one, is denied
  wire goRec = (reqSt == PS_DBGREC);
  wire goClean = modeOn & (((reqSt == PS_OFF) & offWanted & ~emuBit) |
                           ((reqSt == PS_EMU) & emuWanted));
  wire goRet = modeOn & (reqSt == PS_RET) & retWanted;
  wire toOn = (reqSt == PS_ON) & ~modeOn & ~modeRet;
  wire goInv = toOn & ~skipInv_ff & (modeOff | modeEmu);
  wire goNow = goRec | goRet | (modeRet & (reqSt == PS_ON)) | (toOn & ~goInv) |
               (modeOff & (reqSt == PS_EMU)) |
               ((modeEmu | (mode_ff == PS_DBGREC)) & (reqSt == PS_OFF));
  wire goDeny = ~(goRec | goClean | goNow | goInv);
  wire initLegal = (reqSt == PS_OFF) | (reqSt == PS_ON) | (reqSt == PS_DBGREC);

  cpm_ret_timer uWfiTmr (
    .core_clk(core_clk),
    .rstn(rstn),
    .idle(wfiState & ~anyReq),
    .timeout(ctrl_ff[CTRL_WFI_LSB +: TO_W]),
    .expired(wfiExp)
  );
  cpm_ret_timer uWfeTmr (
    .core_clk(core_clk),
    .rstn(rstn),
    .idle(wfeState & ~anyReq),
    .timeout(ctrl_ff[CTRL_WFE_LSB +: TO_W]),
    .expired(wfeExp)
  );

  // Handshake next state
  cpm_hs_t nxt_hs;
  cpm_pstate_t nxt_mode;
  logic nxt_accept, nxt_deny;
  always_comb begin
    nxt_hs = hs_ff;
    nxt_mode = mode_ff;
    nxt_accept = paccept_ff;
    nxt_deny = pdeny_ff;
    case (hs_ff)
      HS_IDLE: begin
        if (newReq) begin
          if (goRec || goNow) begin
            nxt_mode = reqSt;
            nxt_accept = 1'b1;
            nxt_hs = HS_DONE;
          end else if (goClean) begin
            nxt_hs = HS_CLEAN;
          end else if (goInv) begin
            nxt_hs = HS_INVAL;
          end else begin
            nxt_deny = 1'b1;
            nxt_hs = HS_DONE;
          end
        end
      end
      HS_CLEAN: begin
        if (cacheCleanDone) begin
          nxt_mode = tgt_ff;
          nxt_accept = 1'b1;
          nxt_hs = HS_DONE;
        end
      end
      HS_INVAL: begin
        if (cacheInvDone) begin
          nxt_mode = tgt_ff;
          nxt_accept = ~quiet_ff;
          nxt_hs = quiet_ff ? HS_IDLE : HS_DONE;
        end
      end
      HS_DONE: begin
        if (!preqS2_ff) begin
          nxt_accept = 1'b0;
          nxt_deny = 1'b0;
          nxt_hs = HS_IDLE;
        end
      end
      default: nxt_hs = HS_IDLE;
    endcase
    // Channel initialisation after reset release
    if (!initDone_ff && initCnt_ff == INIT_WAIT) begin
      nxt_mode = initLegal ? reqSt : PS_OFF;
      if (reqSt == PS_ON) begin
        nxt_mode = PS_OFF;
        nxt_hs = HS_INVAL;
      end
    end
  end

  wire initNow = !initDone_ff && (initCnt_ff == INIT_WAIT);
  // Recovery start sets skip; first arrival in on clears it
  wire nxt_skip = (initNow && reqSt == PS_DBGREC) ? 1'b1 :
                  (nxt_mode == PS_ON && mode_ff != PS_ON) ? 1'b0 : skipInv_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hs_ff <= HS_IDLE;
      mode_ff <= PS_OFF;
      tgt_ff <= PS_OFF;
      paccept_ff <= 1'b0;
      pdeny_ff <= 1'b0;
      initCnt_ff <= '0;
      initDone_ff <= 1'b0;
      skipInv_ff <= 1'b0;
      quiet_ff <= 1'b0;
    end else begin
      hs_ff <= nxt_hs;
      mode_ff <= nxt_mode;
      paccept_ff <= nxt_accept;
      pdeny_ff <= nxt_deny;
      skipInv_ff <= nxt_skip;
      if (!initDone_ff) begin
        initCnt_ff <= initCnt_ff + 2'h1;
      end
      if (initNow) begin
        initDone_ff <= 1'b1;
        quiet_ff <= 1'b1;
        tgt_ff <= PS_ON;
      end else if (newReq) begin
        quiet_ff <= 1'b0;
        tgt_ff <= reqSt;
      end
    end
  end

  // Maintenance strobes, activity hints and access answers
  wire cpm_dom_t nxt_dom = (nxt_mode == PS_OFF) ? DOM_OFF :
                           (nxt_mode == PS_RET) ? DOM_RET : DOM_ON;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cleanReq_ff <= 1'b0;
      invReq_ff <= 1'b0;
      pactive_ff <= '0;
      dbgErr_ff <= 1'b0;
      dbgGrant_ff <= 1'b0;
      funcGrant_ff <= 1'b0;
      stall_ff <= 1'b0;
      isolate_ff <= 1'b1;
      dom_ff <= DOM_OFF;
    end else begin
      cleanReq_ff <= (nxt_hs == HS_CLEAN);
      invReq_ff <= (nxt_hs == HS_INVAL);
      pactive_ff[PA_ON_BIT] <= modeRet ? anyReq :
                               modeOn & (anyReq | ~(retWanted | offWanted));
      pactive_ff[PA_RET_BIT] <= (modeOn | modeRet) & retWanted;
      pactive_ff[PA_EMU_BIT] <= modeOn & emuWanted;
      pactive_ff[PA_OFF_BIT] <= 1'b0;
      pactive_ff[4:2] <= '0;
      pactive_ff[7:6] <= '0;
      dbgErr_ff <= dbgReq & modeOff & initDone_ff;
      dbgGrant_ff <= dbgReq & (modeOn | modeEmu);
      funcGrant_ff <= (snoopReq | gicReq) & modeOn;
      stall_ff <= anyReq & modeRet;
      // Clamp enable for the integrator's isolation cells
      isolate_ff <= (nxt_dom != DOM_ON);
      // Integrator gates the core clock from this state
      dom_ff <= nxt_dom;
    end
  end

  // AXI4-Lite slave
  logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
  logic awready_ff, wready_ff, arready_ff;
  logic [31:0] awAddr_ff, wData_ff, rdata_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  wire awTake = s_axi_awvalid & awready_ff;
  wire wTake = s_axi_wvalid & wready_ff;
  wire arTake = s_axi_arvalid & arready_ff;
  wire doWrite = awHeld_ff & wHeld_ff & ~bvalid_ff;
  wire nxt_awHeld = awTake | (awHeld_ff & ~doWrite);
  wire nxt_wHeld = wTake | (wHeld_ff & ~doWrite);
  wire nxt_bvalid = doWrite | (bvalid_ff & ~s_axi_bready);
  wire nxt_rvalid = arTake | (rvalid_ff & ~s_axi_rready);
  wire wrCtrl = doWrite & addrHit(awAddr_ff, REG_CTRL_ADDR);
  wire wrStat = doWrite & addrHit(awAddr_ff, REG_STAT_ADDR);
  wire rdCtrl = addrHit(s_axi_araddr, REG_CTRL_ADDR);
  wire rdStat = addrHit(s_axi_araddr, REG_STAT_ADDR);
  wire [31:0] statWord = (32'(mode_ff) << STAT_MODE_LSB) | (32'(dom_ff) << STAT_DOM_LSB) |
                         (32'(skipInv_ff) << STAT_SKIP_BIT) |
                         (32'(stall_ff) << STAT_STALL_BIT) | (32'(hs_ff) << STAT_HS_LSB);
  wire [31:0] rdWord = rdCtrl ? 32'(ctrl_ff) : (rdStat ? statWord : 32'h0000_0000);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      rdata_ff <= '0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      ctrl_ff <= CTRL_RESET;
    end else begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      awready_ff <= ~nxt_awHeld & ~nxt_bvalid;
      wready_ff <= ~nxt_wHeld & ~nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        bresp_ff <= (wrCtrl | wrStat) ? RESP_OKAY : RESP_SLVERR;
      end
      // Only the low byte carries control fields
      if (wrCtrl && wStrb_ff[0]) begin
        ctrl_ff <= wData_ff[7:0];
      end
      if (arTake) begin
        rdata_ff <= rdWord;
        rresp_ff <= (rdCtrl | rdStat) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign paccept = paccept_ff;
  assign pdeny = pdeny_ff;
  assign pactive = pactive_ff;
  assign cacheCleanReq = cleanReq_ff;
  assign cacheInvReq = invReq_ff;
  assign dbgErr = dbgErr_ff;
  assign dbgGrant = dbgGrant_ff;
  assign funcGrant = funcGrant_ff;
  assign accessStall = stall_ff;
  assign funcIsolate = isolate_ff;
  assign domState = dom_ff;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence sCleanEnd;
    (hs_ff == HS_CLEAN) && cacheCleanDone;
  endsequence
  sequence sAccepted;
    paccept_ff && (hs_ff == HS_DONE);
  endsequence

  AST_CLEAN_BEFORE_OFF: assert property (
    $rose(paccept_ff) && modeOff && $past(modeOn) |-> $past(cleanReq_ff))
    else $error("off entered without cache clean");
  AST_CLEAN_ACCEPT: assert property (sCleanEnd |=> sAccepted)
    else $error("clean done not followed by accept");
  AST_DBG_ERR_OFF: assert property (
    dbgReq && modeOff && initDone_ff |=> dbgErr_ff && !dbgGrant_ff)
    else $error("debug in off without error");
  AST_DBG_EMU: assert property (dbgReq && modeEmu |=> dbgGrant_ff && !funcGrant_ff)
    else $error("debug refused in emulated off");
  AST_RET_FROM_WAIT: assert property (
    $rose(paccept_ff) && modeRet && $past(modeOn) |-> $past(wfiState || wfeState, 2))
    else $error("retention entered outside wait");
  AST_STALL_ON_BIT: assert property (
    modeRet && anyReq && !nxt_accept |=> stall_ff && pactive_ff[PA_ON_BIT])
    else $error("access in retention not stalled");
  AST_INV_OFF_TO_ON: assert property (
    newReq && modeOff && reqSt == PS_ON && !skipInv_ff |=> invReq_ff ##0 !paccept_ff)
    else $error("off to on without invalidate");
  AST_SKIP_INV: assert property (
    newReq && skipInv_ff && reqSt == PS_ON |=> !invReq_ff && paccept_ff)
    else $error("recovery start did not skip invalidate");
  AST_REC_NOW: assert property (newReq && reqSt == PS_DBGREC |=> sAccepted)
    else $error("recovery request not accepted at once");
  AST_DOM_MAP: assert property (
    (modeOff |-> dom_ff == DOM_OFF) and (modeRet |-> dom_ff == DOM_RET))
    else $error("domain state mismatch");
  AST_DENY_STALE: assert property (
    newReq && modeOn && reqSt == PS_RET && !retWanted |=> pdeny_ff && !paccept_ff)
    else $error("stale retention request not denied");
  AST_OFF_BIT_LOW: assert property (!pactive_ff[PA_OFF_BIT])
    else $error("off active bit not low");
endmodule

// ---- tb/cpm_pctrl.sv ----
// Power controller model driving the core P-Channel
`timescale 1ns/1ps
module cpm_pctrl
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bench command
  input wire logic go,
  input wire logic [PSTATE_W-1:0] goState,
  input wire logic [PSTATE_W-1:0] initState,
  // P-Channel
  output logic preq,
  output logic [PSTATE_W-1:0] pstate,
  input wire logic paccept,
  input wire logic pdeny,
  // Result
  output logic busy,
  output logic accepted
);
  logic [1:0] phase_ff;
  logic preq_ff;
  logic acc_ff;
  logic [PSTATE_W-1:0] code_ff;
  logic used_ff;
  assign preq = preq_ff;
  // Init code shows until the first request, so reset loads only constants
  assign pstate = used_ff ? code_ff : initState;
  assign accepted = acc_ff;
  assign busy = phase_ff != 2'h0;
  // Code stays put after the request drops, the device samples it late
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 2'h0;
      preq_ff <= 1'h0;
      acc_ff <= 1'h0;
      code_ff <= '0;
      used_ff <= 1'h0;
    end else begin
      case (phase_ff)
        2'h0: if (go) begin
          code_ff <= goState;
          used_ff <= 1'h1;
          preq_ff <= 1'h1;
          phase_ff <= 2'h1;
        end
        2'h1: if (paccept || pdeny) begin
          acc_ff <= paccept;
          preq_ff <= 1'h0;
          phase_ff <= 2'h2;
        end
        default: if (!paccept && !pdeny) begin
          phase_ff <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ---- tb/cpm_core_power_tb.sv ----
// Self-checking bench for the core power-mode block
`timescale 1ns/1ps
module cpm_core_power_tb
  import cpm_pkg::*;
;
  logic core_clk = 1'h0, rstn = 1'h0, go = 1'h0, busy, accepted, preq, paccept, pdeny;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, domState;
  logic [5:0] pstate, goState = 6'h00, initState = 6'h00;
  logic [8:0] pactive;
  logic wfiState = 1'h0, wfeState = 1'h0, snoopReq = 1'h0, gicReq = 1'h0, dbgReq = 1'h0;
  logic cacheCleanReq, cacheCleanDone = 1'h0, cacheInvReq, cacheInvDone = 1'h0;
  logic dbgErr, dbgGrant, funcGrant, accessStall, funcIsolate, sawInv = 1'h0, sawClean = 1'h0;
  int failures = 0, check_count = 0;

  cpm_core_power uut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .preq, .pstate, .paccept, .pdeny, .pactive, .wfiState,
    .wfeState, .snoopReq, .gicReq, .dbgReq, .cacheCleanReq, .cacheCleanDone, .cacheInvReq,
    .cacheInvDone, .dbgErr, .dbgGrant, .funcGrant, .accessStall, .funcIsolate, .domState);
  cpm_pctrl pctl (.core_clk, .rstn, .go, .goState, .initState, .preq, .pstate, .paccept,
    .pdeny, .busy, .accepted);

  initial forever #5 core_clk = ~core_clk;

  // Cache maintenance answers one cycle after each request
  always @(posedge core_clk) begin
    cacheCleanDone <= cacheCleanReq;
    cacheInvDone <= cacheInvReq;
    if (cacheInvReq) sawInv <= 1'h1;
    if (cacheCleanReq) sawClean <= 1'h1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic limit(input int n, input string msg);
    if (n >= 200) begin
      failures++;
      $display("wrong value at %0t ns: timeout %s", $time, msg);
      end_of_test();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic doReset(input logic [5:0] init);
    @(posedge core_clk);
    rstn <= 1'h0;
    initState <= init;
    tick(2);
    rstn <= 1'h1;
    tick(6);
  endtask

  task automatic axiWr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      limit(n, "write");
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic axiRd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      limit(n, "read");
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // One full four-phase exchange, judged on accept versus deny
  task automatic pReq(input logic [5:0] st, input logic expAcc, input string msg);
    int n;
    @(posedge core_clk);
    go <= 1'h1;
    goState <= st;
    @(posedge core_clk);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      limit(n, msg);
    end while (busy !== 1'h0);
    check(accepted, expAcc, msg);
  endtask

  task automatic waitAct(input int b, input logic v);
    int n;
    n = 0;
    while (pactive[b] !== v) begin
      @(posedge core_clk);
      n++;
      limit(n, "pactive");
    end
  endtask

  task automatic testOff();
    check(domState, DOM_OFF, "init off");
    check(funcIsolate, 1'h1, "off iso");
    check(pactive, 9'h000, "off act");
    dbgReq <= 1'h1;
    tick(2);
    check(dbgErr, 1'h1, "dbg err");
    check(dbgGrant, 1'h0, "dbg grant");
    dbgReq <= 1'h0;
    $display("off test done");
  endtask

  task automatic testUp();
    logic [31:0] d;
    logic [1:0] r;
    sawInv <= 1'h0;
    pReq(PS_ON, 1'h1, "up");
    check(sawInv, 1'h1, "inval");
    check(funcIsolate, 1'h0, "up iso");
    axiRd(REG_STAT_ADDR, d, r);
    check(d[9:0], 10'h208, "status");
    axiWr(REG_CTRL_ADDR, 32'h0000_00ff, r);
    check(r, RESP_OKAY, "ctrl wr");
    axiRd(REG_CTRL_ADDR, d, r);
    check(d, 32'h0000_00ff, "ctrl rd");
    axiWr(32'h0000_0010, 32'h0000_0000, r);
    check(r, RESP_SLVERR, "bad wr");
    axiRd(32'h0000_0010, d, r);
    check(d, 32'h0000_0000, "bad data");
    check(r, RESP_SLVERR, "bad rd");
    $display("power-up and register test done");
  endtask

  // Retention from one wait state; the other state's timeout must not count
  task automatic testRet(input int i);
    logic [1:0] r;
    axiWr(REG_CTRL_ADDR, (i == 0) ? 32'h0000_0010 : 32'h0000_0002, r);
    wfiState <= (i == 0);
    wfeState <= (i == 1);
    tick(30);
    check(pactive[PA_RET_BIT], 1'h0, "other timeout");
    axiWr(REG_CTRL_ADDR, (i == 0) ? 32'h0000_0002 : 32'h0000_0010, r);
    waitAct(PA_RET_BIT, 1'h1);
    check(pactive, 9'h020, "ret wanted");
    pReq(PS_RET, 1'h1, "ret");
    check(domState, DOM_RET, "ret dom");
    check(funcIsolate, 1'h1, "ret iso");
    snoopReq <= (i == 0);
    gicReq <= (i == 1);
    tick(3);
    check(accessStall, 1'h1, "stall");
    check(pactive[PA_ON_BIT], 1'h1, "on bit");
    check(funcGrant, 1'h0, "held off");
    pReq(PS_ON, 1'h1, "wake");
    tick(1);
    check(funcGrant, 1'h1, "grant");
    snoopReq <= 1'h0;
    gicReq <= 1'h0;
    tick(4);
    check(pactive[PA_ON_BIT], 1'h1, "on kept");
    waitAct(PA_ON_BIT, 1'h0);
    check(pactive, 9'h020, "on dropped");
    wfiState <= 1'h0;
    wfeState <= 1'h0;
    $display("retention test %0d done", i);
  endtask

  task automatic testDown();
    logic [1:0] r;
    axiWr(REG_CTRL_ADDR, 32'h0000_0000, r);
    pReq(PS_RET, 1'h0, "ret deny");
    pReq(PS_OFF, 1'h0, "off deny");
    axiWr(REG_CTRL_ADDR, 32'h0000_0001, r);
    pReq(PS_OFF, 1'h0, "no wait");
    wfiState <= 1'h1;
    sawClean <= 1'h0;
    tick(2);
    check(pactive, 9'h000, "off wanted");
    axiWr(REG_CTRL_ADDR, 32'h0000_0081, r);
    tick(2);
    check(pactive, 9'h002, "emu wanted");
    axiWr(REG_CTRL_ADDR, 32'h0000_0001, r);
    tick(2);
    pReq(PS_OFF, 1'h1, "down");
    check(sawClean, 1'h1, "clean");
    check(domState, DOM_OFF, "off dom");
    wfiState <= 1'h0;
    $display("powerdown test done");
  endtask

  task automatic testEmuRec();
    pReq(PS_EMU, 1'h1, "emu");
    check(domState, DOM_ON, "emu dom");
    dbgReq <= 1'h1;
    snoopReq <= 1'h1;
    tick(3);
    check(dbgGrant, 1'h1, "emu dbg");
    check(funcGrant, 1'h0, "emu func");
    dbgReq <= 1'h0;
    pReq(PS_OFF, 1'h1, "emu off");
    pReq(PS_ON, 1'h1, "on again");
    sawClean <= 1'h0;
    pReq(PS_DBGREC, 1'h1, "recovery");
    check(sawClean, 1'h0, "no quiesce");
    check(domState, DOM_ON, "rec dom");
    snoopReq <= 1'h0;
    doReset(PS_DBGREC);
    sawInv <= 1'h0;
    pReq(PS_ON, 1'h1, "rec up");
    check(sawInv, 1'h0, "kept caches");
    $display("emulated off and recovery test done");
  endtask

  initial begin
    doReset(PS_OFF);
    testOff();
    testUp();
    testRet(0);
    testRet(1);
    testDown();
    testEmuRec();
    end_of_test();
  end
endmodule
